// ---- src/hbad_decoder.sv ----
// Behaviour
// - Claim 4GB to 64GB accesses, drop writes, return zeros.
// - Reserve 64KB at 0FEC00000h for interrupt-routing units.
// - Unit x decoded at FEC0x000h, sixteen units.
// - Unit space base is reset vector minus 013FFFF0h.
// - Top 2MB below 4GB decodes to firmware.
// - While shadowing, reads go to ROM, writes to RAM.
// - After shadowing, processor reads go to RAM.
// - PCI/ISA accesses to shadowed blocks never reach processor bus.
// - SYSTEM_MGMT_MODE RAM location comes from programmable control register.
// - Enable clear: strobed Smm_window_range accesses ignored.
// - Enable set: strobed Smm_window_range accesses claimed.
// - Strobe off: Smm_window_range decoded by the normal map, not as SMM RAM.
// - RTC index byte: bit 7 NMI mask, bits 6-0 index.
// - Port 0092h decodes uniquely, not a page alias.
// - 1GB to 4GB memory goes to PCI, except the top 2MB firmware and the 64KB unit space.
// - 0A0000h-0BFFFFh goes to PCI; default SYSTEM_MGMT_MODE window.
// - 0 to 07FFFFh main memory unless inside a strobed Smm_window_range.
`timescale 1ns/1ps
`include "hbad_cfg.svh"

module hbad_decoder
(
   input  wire logic                  mclk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  req_valid_in,
   input  wire logic [35:0]           req_addr_in,
   input  wire logic                  req_write_in,
   input  wire logic                  req_io_in,
   input  wire logic                  req_from_pci_in,
   input  wire logic [7:0]            req_wdata_in,
   input  wire logic                  smm_access_strobe_n_in,
   input  wire logic                  cfg_wr_in,
   input  wire logic                  cfg_rd_in,
   input  wire logic [7:0]            cfg_addr_in,
   input  wire logic [7:0]            cfg_wdata_in,
   output logic [7:0]                 cfg_rdata_out,
   output logic                       dec_valid_out,
   output hbad_pkg::hbad_target_t     dec_target_out,
   output logic                       claim_out,
   output logic                       rd_zero_out,
   output logic                       host_fwd_out,
   output logic [3:0]                 ioapic_unit_out,
   output logic                       sys_ctrl_sel_out,
   output logic                       nmi_mask_out,
   output logic [6:0]                 rtc_index_out
);
   import hbad_pkg::*;

   localparam logic [31:0] IOAPIC_BASE =
      `HBAD_RESET_VECTOR - `HBAD_IOAPIC_DELTA;

   // =======================================================
   // Address classification helpers
   // =======================================================
   function automatic logic [3:0] blk_index(input logic [35:0] a);
      if (a[19:16] == `HBAD_BLK_F_SEG)
         return `HBAD_BLK_F_IDX;
      else if (a[19:16] == `HBAD_BLK_E_SEG)
         return {2'b10, a[15:14]};
      else
         return {1'b0, a[16:14]};
   endfunction : blk_index

   function automatic logic in_shadow(input logic [35:0] a);
      return (a >= `HBAD_SHADOW_BASE) && (a < `HBAD_SHADOW_TOP);
   endfunction : in_shadow

   function automatic logic in_smm(input logic [35:0] a,
                                   input logic [7:0]  ctl);
      // 128KB window selected by the low three control bits
      return a[35:17] == {16'h0000, ctl[2:0]};
   endfunction : in_smm

   // =======================================================
   // Request stage and attribute lookup
   // =======================================================
   logic        s1_valid;
   logic [35:0] s1_addr;
   logic        s1_write;
   logic        s1_io;
   logic        s1_pci;
   logic        s1_smm;
   logic [7:0]  s1_wdata;
   logic        next_s1_valid;
   logic [35:0] next_s1_addr;
   logic        next_s1_write;
   logic        next_s1_io;
   logic        next_s1_pci;
   logic        next_s1_smm;
   logic [7:0]  next_s1_wdata;
   hbad_attr_t  attr_rd;
   logic        attr_wr_en;

   // Attribute writes land before the next lookup edge
   assign attr_wr_en = cfg_wr_in && (cfg_addr_in >= `HBAD_ATTR_FIRST_OFS)
                       && (cfg_addr_in <= `HBAD_ATTR_LAST_OFS);

   hbad_attr_mem u_attr_mem
   (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .wr_en_in    (attr_wr_en),
      .wr_addr_in  (4'(cfg_addr_in - `HBAD_ATTR_FIRST_OFS)),
      .wr_data_in  (cfg_wdata_in[1:0]),
      .rd_addr_in  (blk_index(req_addr_in)),
      .rd_data_out (attr_rd)
   );

   always_comb
   begin
      next_s1_valid = req_valid_in;
      next_s1_addr  = s1_addr;
      next_s1_write = s1_write;
      next_s1_io    = s1_io;
      next_s1_pci   = s1_pci;
      next_s1_smm   = s1_smm;
      next_s1_wdata = s1_wdata;
      if (req_valid_in)
      begin
         next_s1_addr  = req_addr_in;
         next_s1_write = req_write_in;
         next_s1_io    = req_io_in;
         next_s1_pci   = req_from_pci_in;
         // Strobe is sampled with the request phase only
         next_s1_smm   = !smm_access_strobe_n_in && !req_from_pci_in;
         next_s1_wdata = req_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s1_valid <= 1'b0;
         s1_addr  <= 36'h0_0000_0000;
         s1_write <= 1'b0;
         s1_io    <= 1'b0;
         s1_pci   <= 1'b0;
         s1_smm   <= 1'b0;
         s1_wdata <= 8'h00;
      end
      else
      begin
         s1_valid <= next_s1_valid;
         s1_addr  <= next_s1_addr;
         s1_write <= next_s1_write;
         s1_io    <= next_s1_io;
         s1_pci   <= next_s1_pci;
         s1_smm   <= next_s1_smm;
         s1_wdata <= next_s1_wdata;
      end
   end

   // =======================================================
   // Decode, configuration and legacy port state
   // =======================================================
   logic [7:0]   smm_ctl;
   logic [7:0]   next_smm_ctl;
   logic [7:0]   next_cfg_rdata;
   hbad_target_t tgt;
   hbad_target_t next_target;
   logic         next_dec_valid;
   logic         next_rd_zero;
   logic         next_host_fwd;
   logic [3:0]   next_ioapic_unit;
   logic         next_sys_ctrl_sel;
   logic         next_nmi_mask;
   logic [6:0]   next_rtc_index;
   logic         smm_en;

   assign smm_en = smm_ctl[`HBAD_SMM_EN_BIT];

   always_comb
   begin
      tgt = HBAD_TGT_NONE;
      if (s1_io)
      begin
         if (s1_addr[15:0] == `HBAD_SYS_CTRL_PORT)
            tgt = HBAD_TGT_SYSCTL;
         else
            tgt = HBAD_TGT_PCI;
      end
      else if (s1_addr >= `HBAD_TERM_BASE)
         tgt = HBAD_TGT_TERM;
      else if (s1_smm && in_smm(s1_addr, smm_ctl))
         tgt = smm_en ? HBAD_TGT_SMM_RAM
                      : HBAD_TGT_NONE;
      else if (s1_addr < `HBAD_DOS_TOP)
         tgt = HBAD_TGT_MAIN;
      else if (s1_addr < `HBAD_VGA_BASE)
         tgt = HBAD_TGT_MAIN;
      else if (s1_addr < `HBAD_SHADOW_BASE)
         tgt = HBAD_TGT_PCI;
      else if (in_shadow(s1_addr))
      begin
         if (s1_pci)
            tgt = (attr_rd != 2'h0) ? HBAD_TGT_NONE
                                    : HBAD_TGT_PCI;
         else if (s1_write)
            tgt = attr_rd[`HBAD_ATTR_WR_BIT] ? HBAD_TGT_MAIN
                                             : HBAD_TGT_PCI;
         else
            tgt = attr_rd[`HBAD_ATTR_RD_BIT] ? HBAD_TGT_MAIN
                                             : HBAD_TGT_PCI;
      end
      else if (s1_addr < `HBAD_MAIN_TOP)
         tgt = HBAD_TGT_MAIN;
      else if (s1_addr >= `HBAD_BIOS_BASE)
         tgt = HBAD_TGT_BIOS;
      else if (s1_addr[35:16] == {4'h0, IOAPIC_BASE[31:16]})
         tgt = HBAD_TGT_IOAPIC;
      else
         tgt = HBAD_TGT_PCI;
   end

   always_comb
   begin
      next_smm_ctl      = smm_ctl;
      next_cfg_rdata    = 8'h00;
      next_dec_valid    = s1_valid;
      next_target       = dec_target_out;
      next_rd_zero      = 1'b0;
      next_host_fwd     = 1'b0;
      next_ioapic_unit  = ioapic_unit_out;
      next_sys_ctrl_sel = 1'b0;
      next_nmi_mask     = nmi_mask_out;
      next_rtc_index    = rtc_index_out;
      if (cfg_wr_in && cfg_addr_in == `HBAD_SMM_CTL_OFS)
         next_smm_ctl = cfg_wdata_in;
      if (cfg_rd_in)
      begin
         if (cfg_addr_in == `HBAD_SMM_CTL_OFS)
            next_cfg_rdata = smm_ctl;
         else if (cfg_addr_in == `HBAD_STATUS_OFS)
            next_cfg_rdata = {4'h0, claim_out, dec_target_out};
      end
      if (s1_valid)
      begin
         next_target      = tgt;
         next_rd_zero     = (tgt == HBAD_TGT_TERM) && !s1_write;
         next_host_fwd    = s1_pci && (tgt == HBAD_TGT_MAIN);
         next_ioapic_unit = s1_addr[15:12];
         next_sys_ctrl_sel = (tgt == HBAD_TGT_SYSCTL);
         if (s1_io && s1_write && ((s1_addr[15:0] & `HBAD_RTC_ALIAS_MASK)
             == `HBAD_RTC_IDX_PORT))
         begin
            next_nmi_mask  = s1_wdata[`HBAD_NMI_MASK_BIT];
            next_rtc_index = s1_wdata[6:0];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         smm_ctl          <= `HBAD_SMM_CTL_RESET;
         cfg_rdata_out    <= 8'h00;
         dec_valid_out    <= 1'b0;
         dec_target_out   <= HBAD_TGT_NONE;
         rd_zero_out      <= 1'b0;
         host_fwd_out     <= 1'b0;
         ioapic_unit_out  <= 4'h0;
         sys_ctrl_sel_out <= 1'b0;
         nmi_mask_out     <= 1'b0;
         rtc_index_out    <= 7'h00;
      end
      else
      begin
         smm_ctl          <= next_smm_ctl;
         cfg_rdata_out    <= next_cfg_rdata;
         dec_valid_out    <= next_dec_valid;
         dec_target_out   <= next_target;
         rd_zero_out      <= next_rd_zero;
         host_fwd_out     <= next_host_fwd;
         ioapic_unit_out  <= next_ioapic_unit;
         sys_ctrl_sel_out <= next_sys_ctrl_sel;
         nmi_mask_out     <= next_nmi_mask;
         rtc_index_out    <= next_rtc_index;
      end
   end

   // Claim is a pure function of the registered valid and target
   assign claim_out = dec_valid_out && (dec_target_out != HBAD_TGT_NONE);

   // =======================================================
   // Checks
   // =======================================================
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_mem_req(logic c);
      req_valid_in && !req_io_in && c;
   endsequence

   sequence s_decoded(hbad_target_t t);
      ##2 dec_valid_out && dec_target_out == t;
   endsequence

   a_above_4g_term: assert property (
      s_mem_req(req_addr_in[35:32] != 4'h0)
      |-> ##2 dec_target_out == HBAD_TGT_TERM && claim_out
          && rd_zero_out == !$past(req_write_in, 2))
      else $error("above 4GB access not terminated");
   a_ioapic_unit_sel: assert property (
      s_mem_req(req_addr_in[35:16] == 20'h0_FEC0)
      |-> s_decoded(HBAD_TGT_IOAPIC)
          ##0 ioapic_unit_out == $past(req_addr_in[15:12], 2))
      else $error("interrupt unit window misdecoded");
   a_bios_top_2mb: assert property (
      s_mem_req(req_addr_in[35:21] == 15'h07FF) |-> s_decoded(HBAD_TGT_BIOS))
      else $error("top 2MB not routed to firmware");
   a_shadow_host_read: assert property (
      s1_valid && !s1_io && !s1_pci && !s1_write && in_shadow(s1_addr)
      && !(s1_smm && in_smm(s1_addr, smm_ctl))
      |=> dec_target_out == ($past(attr_rd[`HBAD_ATTR_RD_BIT])
                             ? HBAD_TGT_MAIN : HBAD_TGT_PCI))
      else $error("shadow read routed against attribute");
   a_shadow_pci_block: assert property (
      dec_valid_out && host_fwd_out |-> dec_target_out == HBAD_TGT_MAIN
      && !in_shadow($past(s1_addr)))
      else $error("PCI access to shadow block forwarded");
   a_smm_disabled_ign: assert property (
      s_mem_req(!smm_access_strobe_n_in && !req_from_pci_in
                && req_addr_in[35:32] == 4'h0
                && in_smm(req_addr_in, smm_ctl) && !smm_en
                && !cfg_wr_in)
      |-> ##2 dec_valid_out && !claim_out)
      else $error("disabled Smm_window_range claimed");
   a_smm_enabled_claim: assert property (
      s_mem_req(!smm_access_strobe_n_in && !req_from_pci_in
                && req_addr_in[35:32] == 4'h0
                && in_smm(req_addr_in, smm_ctl) && smm_en
                && !cfg_wr_in)
      |-> s_decoded(HBAD_TGT_SMM_RAM) ##0 claim_out)
      else $error("enabled Smm_window_range not claimed");
   a_smm_strobe_off: assert property (
      s_mem_req(smm_access_strobe_n_in) |-> ##2 dec_target_out
      != HBAD_TGT_SMM_RAM)
      else $error("Smm_window_range decoded without strobe");
   a_rtc_index_split: assert property (
      req_valid_in && req_io_in && req_write_in
      && req_addr_in[15:0] == `HBAD_RTC_IDX_PORT
      |-> ##2 nmi_mask_out == $past(req_wdata_in[7], 2)
          && rtc_index_out == $past(req_wdata_in[6:0], 2))
      else $error("RTC index byte not split");
   a_sysctl_unique: assert property (
      req_valid_in && req_io_in |-> ##2 sys_ctrl_sel_out
      == ($past(req_addr_in[15:0], 2) == `HBAD_SYS_CTRL_PORT))
      else $error("system control port aliased");
   a_dos_area_main: assert property (
      s_mem_req(req_addr_in < `HBAD_DOS_TOP && smm_access_strobe_n_in)
      |-> s_decoded(HBAD_TGT_MAIN))
      else $error("DOS area not in main memory");

endmodule : hbad_decoder

// ---- shared/hbad_cfg.svh ----
`ifndef HBAD_CFG_SVH
`define HBAD_CFG_SVH

// ==========================================================
// Configuration register offsets and layout
// ==========================================================
`define HBAD_ATTR_FIRST_OFS  8'h60
`define HBAD_ATTR_LAST_OFS   8'h6C
`define HBAD_SMM_CTL_OFS     8'h72
`define HBAD_STATUS_OFS      8'h7F
`define HBAD_SMM_CTL_RESET   8'h05
`define HBAD_SMM_EN_BIT      3
`define HBAD_ATTR_RD_BIT     0
`define HBAD_ATTR_WR_BIT     1

// ==========================================================
// Memory map boundaries (36-bit host address)
// ==========================================================
`define HBAD_DOS_TOP         36'h0_0008_0000
`define HBAD_VGA_BASE        36'h0_000A_0000
`define HBAD_SHADOW_BASE     36'h0_000C_0000
`define HBAD_SHADOW_TOP      36'h0_0010_0000
`define HBAD_MAIN_TOP        36'h0_4000_0000
`define HBAD_TERM_BASE       36'h1_0000_0000
`define HBAD_BIOS_BASE       36'h0_FFE0_0000
`define HBAD_RESET_VECTOR    32'hFFFF_FFF0
`define HBAD_IOAPIC_DELTA    32'h013F_FFF0
`define HBAD_BLK_E_SEG       4'hE
`define HBAD_BLK_F_SEG       4'hF
`define HBAD_BLK_F_IDX       4'hC

// ==========================================================
// Legacy I/O ports
// ==========================================================
`define HBAD_RTC_IDX_PORT    16'h0070
`define HBAD_RTC_ALIAS_MASK  16'hFFF9
`define HBAD_SYS_CTRL_PORT   16'h0092
`define HBAD_NMI_MASK_BIT    7

`endif

// ---- shared/hbad_pkg.sv ----
package hbad_pkg;

   // =======================================================
   // Decode targets
   // =======================================================
   typedef enum logic [2:0]
   {
      HBAD_TGT_NONE,
      HBAD_TGT_MAIN,
      HBAD_TGT_PCI,
      HBAD_TGT_BIOS,
      HBAD_TGT_IOAPIC,
      HBAD_TGT_TERM,
      HBAD_TGT_SMM_RAM,
      HBAD_TGT_SYSCTL
   } hbad_target_t;

   typedef logic [1:0] hbad_attr_t;

endpackage : hbad_pkg

// ---- src/hbad_attr_mem.sv ----
`timescale 1ns/1ps

// ==========================================================
// Per-block shadow attribute store, registered read
// ==========================================================
module hbad_attr_mem
(
   input  wire logic              mclk_in,
   input  wire logic              rst_n_in,
   input  wire logic              wr_en_in,
   input  wire logic [3:0]        wr_addr_in,
   input  wire hbad_pkg::hbad_attr_t wr_data_in,
   input  wire logic [3:0]        rd_addr_in,
   output hbad_pkg::hbad_attr_t   rd_data_out
);
   import hbad_pkg::*;

   hbad_attr_t mem [16];
   hbad_attr_t next_mem [16];
   hbad_attr_t next_rd_data;

   always_comb
   begin
      next_mem = mem;
      if (wr_en_in)
      begin
         next_mem[wr_addr_in] = wr_data_in;
      end
      next_rd_data = mem[rd_addr_in];
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < 16; i++)
         begin
            mem[i] <= 2'h0;
         end
         rd_data_out <= 2'h0;
      end
      else
      begin
         mem         <= next_mem;
         rd_data_out <= next_rd_data;
      end
   end

endmodule : hbad_attr_mem

// ---- bench/hbad_host_model.sv ----
`timescale 1ns/1ps

// ==========================================================
// Host processor bus master
// ==========================================================
module hbad_host_model
(
   input  wire logic        mclk_in,
   output logic             req_valid_out,
   output logic [35:0]      req_addr_out,
   output logic             req_write_out,
   output logic             req_io_out,
   output logic             req_from_pci_out,
   output logic [7:0]       req_wdata_out,
   output logic             smm_access_strobe_n_out,
   output logic             mgmt_interrupt_req_n_out
);
   initial
   begin
      req_valid_out = 1'b0;
      req_addr_out = 36'h0_0000_0000;
      req_write_out = 1'b0;
      req_io_out = 1'b0;
      req_from_pci_out = 1'b0;
      req_wdata_out = 8'h00;
      smm_access_strobe_n_out = 1'b1;
      mgmt_interrupt_req_n_out = 1'b1;
   end

   // One request phase; sig is {write, io, from_pci, strobe_n}
   task automatic send(input logic [35:0] a, input logic [3:0] sig,
                       input logic [7:0] d);
      @(posedge mclk_in);
      req_valid_out <= 1'b1;
      req_addr_out <= a;
      req_write_out <= sig[3];
      req_io_out <= sig[2];
      req_from_pci_out <= sig[1];
      req_wdata_out <= d;
      smm_access_strobe_n_out <= sig[0];
      mgmt_interrupt_req_n_out <= 1'b1;
      @(posedge mclk_in);
      // Released address, data and type lines show inverted values so stale sampling is caught
      req_valid_out <= 1'b0;
      req_addr_out <= ~a;
      req_wdata_out <= ~d;
      req_write_out <= ~sig[3];
      req_io_out <= ~sig[2];
      req_from_pci_out <= ~sig[1];
      smm_access_strobe_n_out <= 1'b1;
      // Powered-down device may interrupt in the response phase
      mgmt_interrupt_req_n_out <= sig[0];
   endtask : send
endmodule : hbad_host_model

// ---- bench/host_address_decoder_test.sv ----
`timescale 1ns/1ps

`define HBAD_CHK(n, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("mismatch %s exp %0h got %0h", n, e, g); \
      end \
   end

module host_address_decoder_test;
   import hbad_pkg::*;

   typedef struct {
      logic [7:0]   c;
      logic [7:0]   v;
      logic [35:0]  a;
      logic [3:0]   sig;
      hbad_target_t t;
      logic [1:0]   zf;
   } hbad_row_t;

   logic         mclk_in;
   logic         rst_n_in;
   logic         req_valid;
   logic [35:0]  req_addr;
   logic         req_write;
   logic         req_io;
   logic         req_pci;
   logic [7:0]   req_wdata;
   logic         smm_n;
   logic         cfg_wr_in;
   logic         cfg_rd_in;
   logic [7:0]   cfg_addr_in;
   logic [7:0]   cfg_wdata_in;
   logic [7:0]   cfg_rdata_out;
   logic         dec_valid_out;
   hbad_target_t dec_target_out;
   logic         claim_out;
   logic         rd_zero_out;
   logic         host_fwd_out;
   logic [3:0]   ioapic_unit_out;
   logic         sys_ctrl_sel_out;
   logic         nmi_mask_out;
   logic [6:0]   rtc_index_out;
   int           fail_count = 0;
   int           comparisons = 0;
   int           cycles = 0;
   hbad_row_t    rows [35];

   hbad_host_model u_hbad_host_model
   (
      .mclk_in                 (mclk_in),
      .req_valid_out           (req_valid),
      .req_addr_out            (req_addr),
      .req_write_out           (req_write),
      .req_io_out              (req_io),
      .req_from_pci_out        (req_pci),
      .req_wdata_out           (req_wdata),
      .smm_access_strobe_n_out (smm_n),
      .mgmt_interrupt_req_n_out ()
   );

   hbad_decoder u_hbad_decoder
   (
      .mclk_in                (mclk_in),
      .rst_n_in               (rst_n_in),
      .req_valid_in           (req_valid),
      .req_addr_in            (req_addr),
      .req_write_in           (req_write),
      .req_io_in              (req_io),
      .req_from_pci_in        (req_pci),
      .req_wdata_in           (req_wdata),
      .smm_access_strobe_n_in (smm_n),
      .cfg_wr_in              (cfg_wr_in),
      .cfg_rd_in              (cfg_rd_in),
      .cfg_addr_in            (cfg_addr_in),
      .cfg_wdata_in           (cfg_wdata_in),
      .cfg_rdata_out          (cfg_rdata_out),
      .dec_valid_out          (dec_valid_out),
      .dec_target_out         (dec_target_out),
      .claim_out              (claim_out),
      .rd_zero_out            (rd_zero_out),
      .host_fwd_out           (host_fwd_out),
      .ioapic_unit_out        (ioapic_unit_out),
      .sys_ctrl_sel_out       (sys_ctrl_sel_out),
      .nmi_mask_out           (nmi_mask_out),
      .rtc_index_out          (rtc_index_out)
   );

   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   task automatic print_verdict;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // Ceiling well above the roughly 170 cycles the sequence needs
   always @(posedge mclk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      cfg_wr_in <= 1'b1;
      cfg_addr_in <= a;
      cfg_wdata_in <= d;
      @(posedge mclk_in);
      cfg_wr_in <= 1'b0;
   endtask : cfg_wr

   task automatic cfg_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      cfg_rd_in <= 1'b1;
      cfg_addr_in <= a;
      @(posedge mclk_in);
      cfg_rd_in <= 1'b0;
      #1;
      `HBAD_CHK("cfg_rdata", e, cfg_rdata_out)
   endtask : cfg_chk

   // Answer is sampled one edge after the take edge
   task automatic run(input hbad_row_t r, input logic [7:0] d);
      if (r.c != 8'h00)
         cfg_wr(r.c, r.v);
      u_hbad_host_model.send(r.a, r.sig, d);
      @(posedge mclk_in);
      #1;
      `HBAD_CHK("valid", 1'b1, dec_valid_out)
      `HBAD_CHK("target", r.t, dec_target_out)
      `HBAD_CHK("claim", r.t != HBAD_TGT_NONE, claim_out)
      `HBAD_CHK("rd_zero", r.zf[1], rd_zero_out)
      `HBAD_CHK("host_fwd", r.zf[0], host_fwd_out)
      `HBAD_CHK("unit", r.a[15:12], ioapic_unit_out)
      `HBAD_CHK("sysctl", r.t == HBAD_TGT_SYSCTL, sys_ctrl_sel_out)
   endtask : run

   initial
   begin
      rows = '{
         '{8'h00,8'h00,36'h0_0001_0000,4'b0001,HBAD_TGT_MAIN,2'b00},
         '{8'h00,8'h00,36'h0_0007_FFFF,4'b1001,HBAD_TGT_MAIN,2'b00},
         '{8'h00,8'h00,36'h0_000A_0000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_000B_FFFF,4'b1001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_4000_0000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_3FFF_FFFF,4'b0001,HBAD_TGT_MAIN,2'b00},
         '{8'h00,8'h00,36'h0_FFE0_0000,4'b0001,HBAD_TGT_BIOS,2'b00},
         '{8'h00,8'h00,36'h0_FFFF_FFF0,4'b0001,HBAD_TGT_BIOS,2'b00},
         '{8'h00,8'h00,{4'h0,32'hFFFF_FFF0 - 32'h013F_FFF0},4'b0001,
           HBAD_TGT_IOAPIC,2'b00},
         '{8'h00,8'h00,36'h0_FEC0_F000,4'b1001,HBAD_TGT_IOAPIC,2'b00},
         '{8'h00,8'h00,36'h0_FEC1_0000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_FEBF_FFFF,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h1_0000_0000,4'b0001,HBAD_TGT_TERM,2'b10},
         '{8'h00,8'h00,36'hF_FFFF_FFFF,4'b1001,HBAD_TGT_TERM,2'b00},
         '{8'h00,8'h00,36'h0_0000_0092,4'b1101,HBAD_TGT_SYSCTL,2'b00},
         '{8'h00,8'h00,36'h0_0000_0093,4'b1101,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_0000_0090,4'b0101,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_000A_0000,4'b0000,HBAD_TGT_NONE,2'b00},
         '{8'h00,8'h00,36'h0_0001_0000,4'b0011,HBAD_TGT_MAIN,2'b01},
         '{8'h72,8'h0D,36'h0_000A_0000,4'b0000,HBAD_TGT_SMM_RAM,2'b00},
         '{8'h00,8'h00,36'h0_000B_FFFF,4'b1000,HBAD_TGT_SMM_RAM,2'b00},
         '{8'h00,8'h00,36'h0_000A_0000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h72,8'h0C,36'h0_0008_0000,4'b0000,HBAD_TGT_SMM_RAM,2'b00},
         '{8'h00,8'h00,36'h0_000A_0000,4'b0000,HBAD_TGT_PCI,2'b00},
         '{8'h72,8'h04,36'h0_0008_0000,4'b0000,HBAD_TGT_NONE,2'b00},
         '{8'h00,8'h00,36'h0_0008_0000,4'b0001,HBAD_TGT_MAIN,2'b00},
         '{8'h6C,8'h02,36'h0_000F_0000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_000F_8000,4'b1001,HBAD_TGT_MAIN,2'b00},
         '{8'h6C,8'h01,36'h0_000F_0000,4'b0001,HBAD_TGT_MAIN,2'b00},
         '{8'h00,8'h00,36'h0_000F_FFFF,4'b1001,HBAD_TGT_PCI,2'b00},
         '{8'h00,8'h00,36'h0_000F_0000,4'b0011,HBAD_TGT_NONE,2'b00},
         '{8'h00,8'h00,36'h0_000E_0000,4'b0011,HBAD_TGT_PCI,2'b00},
         '{8'h60,8'h03,36'h0_000C_0000,4'b0001,HBAD_TGT_MAIN,2'b00},
         '{8'h00,8'h00,36'h0_000C_4000,4'b0001,HBAD_TGT_PCI,2'b00},
         '{8'h60,8'h00,36'h0_000C_0000,4'b0001,HBAD_TGT_PCI,2'b00}
      };
      rst_n_in = 1'b0;
      cfg_wr_in = 1'b0;
      cfg_rd_in = 1'b0;
      cfg_addr_in = 8'h00;
      cfg_wdata_in = 8'h00;
      repeat (16) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      cfg_chk(8'h72, 8'h05);
      cfg_wr(8'h50, 8'hFF);
      cfg_chk(8'h50, 8'h00);
      // Rows 0-18 fixed map, 19-25 SYSTEM_MGMT_MODE window, 26-34 shadow attributes
      for (int i = 0; i < 9; i++)
         run(rows[i], 8'h00);
      for (int i = 9; i < 19; i++)
         run(rows[i], 8'h00);
      for (int i = 19; i < 26; i++)
         run(rows[i], 8'h00);
      for (int i = 26; i < 35; i++)
         run(rows[i], 8'h00);
      cfg_chk(8'h6C, 8'h00);
      cfg_chk(8'h72, 8'h04);
      run('{8'h00,8'h00,36'h0_0000_0070,4'b1101,HBAD_TGT_PCI,2'b00}, 8'hC5);
      `HBAD_CHK("nmi_mask", 1'b1, nmi_mask_out)
      `HBAD_CHK("rtc_index", 7'h45, rtc_index_out)
      run('{8'h00,8'h00,36'h0_0000_0076,4'b1101,HBAD_TGT_PCI,2'b00}, 8'h3A);
      `HBAD_CHK("nmi_mask", 1'b0, nmi_mask_out)
      `HBAD_CHK("rtc_index", 7'h3A, rtc_index_out)
      run('{8'h00,8'h00,36'h0_0000_0071,4'b1101,HBAD_TGT_PCI,2'b00}, 8'hFF);
      `HBAD_CHK("rtc_index", 7'h3A, rtc_index_out)
      // Status: claim pulse gone, last target still PCI
      cfg_chk(8'h7F, 8'h02);
      // Reset in mid-run must restore the control register and attributes
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1;
      `HBAD_CHK("target", HBAD_TGT_NONE, dec_target_out)
      `HBAD_CHK("rtc_index", 7'h00, rtc_index_out)
      @(posedge mclk_in);
      rst_n_in <= 1'b1;
      cfg_chk(8'h72, 8'h05);
      run('{8'h00,8'h00,36'h0_000F_0000,4'b0001,HBAD_TGT_PCI,2'b00}, 8'h00);
      print_verdict();
   end
endmodule : host_address_decoder_test
